/* File: shared/lomc_pkg.sv */
// Constants and helpers shared by the overhead framer and its parts
`default_nettype none
package lomc_pkg;
	// Bit timing: 80 kbaud quats, two bits each, from a 200 MHz clock
	localparam int CLK_HZ        = 200_000_000;
	localparam int QUAT_HZ       = 80_000;
	localparam int BITS_PER_QUAT = 2;
	localparam int BIT_DIV       = CLK_HZ / (QUAT_HZ * BITS_PER_QUAT);
	localparam int DIV_W         = 11;
	localparam logic [DIV_W-1:0] DIV_LAST = DIV_W'(BIT_DIV - 1);
	localparam logic [DIV_W-1:0] DIV_ZERO = 11'h000;

	// Bit positions inside a 240-bit basic frame
	localparam int POS_W = 8;
	localparam logic [POS_W-1:0] POS_FIRST = 8'h01;
	localparam logic [POS_W-1:0] FW_LAST   = 8'h12;
	localparam logic [POS_W-1:0] DATA_LAST = 8'hEA;
	localparam logic [POS_W-1:0] M1_POS    = 8'hEB;
	localparam logic [POS_W-1:0] M4_POS    = 8'hEE;
	localparam logic [POS_W-1:0] POS_LAST  = 8'hF0;

	// Basic frame numbers 1..8 held as 0..7
	localparam int FRM_W = 3;
	localparam logic [FRM_W-1:0] FRM_1 = 3'h0;
	localparam logic [FRM_W-1:0] FRM_2 = 3'h1;
	localparam logic [FRM_W-1:0] FRM_3 = 3'h2;
	localparam logic [FRM_W-1:0] FRM_4 = 3'h3;
	localparam logic [FRM_W-1:0] FRM_5 = 3'h4;
	localparam logic [FRM_W-1:0] FRM_7 = 3'h6;
	localparam logic [FRM_W-1:0] FRM_8 = 3'h7;
	localparam logic [1:0]       QTR_LAST = 2'h3;

	// Overhead bit index 0..5 for M1..M6
	localparam logic [2:0] M_IDX_3 = 3'h2;
	localparam logic [2:0] M_IDX_4 = 3'h3;
	localparam logic [2:0] M_IDX_5 = 3'h4;
	localparam logic [2:0] M_IDX_6 = 3'h5;

	// Framing word as sign/magnitude bit pairs, first bit at the top
	localparam int FW_W = 18;
	localparam logic [FW_W-1:0] FW_PATTERN = 18'h2_808A;

	// Check code and operations channel
	localparam int CRC_W = 12;
	localparam logic [CRC_W-1:0] CRC_POLY  = 12'h80F;
	localparam logic [CRC_W-1:0] CRC_CLEAR = 12'h000;
	localparam int EOC_W = 12;
	localparam logic [EOC_W-1:0] EOC_IDLE = 12'hFFF;
	localparam logic [3:0] EOC_PER_FRAME = 4'h3;
	localparam logic [3:0] MSB_IDX       = 4'hB;
	localparam logic RESERVED_BIT = 1'b1;
	localparam logic COLD_IDLE    = 1'b0;

	function automatic logic [2:0] mbit_sel(input logic [POS_W-1:0] pos);
		mbit_sel = 3'(pos - M1_POS);
	endfunction

	// Only 2B+D and M4 feed the check code
	function automatic logic crc_covered(input logic [POS_W-1:0] pos);
		crc_covered = (pos > FW_LAST && pos <= DATA_LAST) || pos == M4_POS;
	endfunction

	// Word bit carried by M1..M3 of a frame, address bit one at the top
	function automatic logic [3:0] eoc_index(input logic [FRM_W-1:0] frm,
			input logic [2:0] m);
		logic [3:0] idx;
		idx = 4'(frm[1:0]) * EOC_PER_FRAME + 4'(m);
		eoc_index = MSB_IDX - idx;
	endfunction

	// Check bit carried by M5/M6 of frames 3..8, check bit one at the top
	function automatic logic [3:0] crc_index(input logic [FRM_W-1:0] frm,
			input logic [2:0] m);
		logic [3:0] idx;
		idx = {3'(frm - FRM_3), 1'b0} + 4'(m - M_IDX_5);
		crc_index = MSB_IDX - idx;
	endfunction
endpackage
`default_nettype wire

/* File: logic/lomc_bit_tick.sv */
// Bit-rate enable divider for the line side
`timescale 1ns/1ps
`default_nettype none
module lomc_bit_tick (
	// Clock and reset
	input  wire logic clk,
	input  wire logic rst,
	// Control and enable out
	input  wire logic enable,
	output logic      tick
);
	logic [lomc_pkg::DIV_W-1:0] count;
	wire logic last = count == lomc_pkg::DIV_LAST;
	wire logic [lomc_pkg::DIV_W-1:0] next_count =
		last ? lomc_pkg::DIV_ZERO : lomc_pkg::DIV_W'(count + 1'b1);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			count <= lomc_pkg::DIV_ZERO;
			tick  <= 1'b0;
		end else if (!enable) begin
			count <= lomc_pkg::DIV_ZERO;
			tick  <= 1'b0;
		end else begin
			count <= next_count;
			tick  <= last;
		end
	end
endmodule
`default_nettype wire

/* File: logic/lomc_crc12.sv */
// Twelve-stage check code generator with clear and freeze
`timescale 1ns/1ps
`default_nettype none
module lomc_crc12 (
	// Clock and reset
	input  wire logic                      clk,
	input  wire logic                      rst,
	// Control and data
	input  wire logic                      clear,
	input  wire logic                      shift,
	input  wire logic                      din,
	// Stage contents, stage 12 at the top
	output logic [lomc_pkg::CRC_W-1:0]     crc
);
	// Bits enter as they are, one as one
	wire logic fb = din ^ crc[lomc_pkg::CRC_W-1];
	// x^12 + x^11 + x^3 + x^2 + x + 1 feedback
	wire logic [lomc_pkg::CRC_W-1:0] next_crc =
		{crc[lomc_pkg::CRC_W-2:0], 1'b0}
		^ ({lomc_pkg::CRC_W{fb}} & lomc_pkg::CRC_POLY);

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			crc <= lomc_pkg::CRC_CLEAR;
		end else if (clear) begin
			crc <= lomc_pkg::CRC_CLEAR;
		end else if (shift) begin
			crc <= next_crc; // Frozen otherwise
		end
	end
endmodule
`default_nettype wire

/* File: logic/lomc_framer.sv */
// Line-end overhead bit framer and check code monitor
`timescale 1ns/1ps
`default_nettype none
module lomc_framer (
	// Clock and reset
	input  wire logic                       CLK,
	input  wire logic                       SYS_RST,
	// Transmit user side
	input  wire logic                       TX_ENABLE,
	input  wire logic                       TX_DATA,
	output logic                            TX_DATA_TAKE,
	input  wire logic [lomc_pkg::EOC_W-1:0] TX_EOC_WORD,
	output logic                            TX_EOC_TAKE,
	input  wire logic                       TX_ACTIVATION_INDICATOR,
	input  wire logic                       TX_DEACTIVATION_INDICATOR,
	input  wire logic                       TX_LINK_LAYER_ONLY_ACTIVATION,
	input  wire logic                       TX_ALARM_INDICATION,
	// Transmit line side
	output logic                            TX_BIT,
	output logic                            TX_BIT_VALID,
	output logic                            TX_FRAMING_WORD,
	output logic                            TX_MF_START,
	// Receive line side
	input  wire logic                       RX_BIT,
	input  wire logic                       RX_BIT_VALID,
	input  wire logic                       RX_MF_START,
	input  wire logic                       RX_SYNC_LOST,
	// Receive user side
	output logic                            RX_LOCKED,
	output logic                            RX_USER_BIT,
	output logic                            RX_USER_VALID,
	output logic [lomc_pkg::EOC_W-1:0]      RX_EOC_WORD,
	output logic                            RX_EOC_VALID,
	// Received indicators
	output logic                            RX_ACTIVATION_INDICATOR,
	output logic                            RX_POWER_STATUS_ONE,
	output logic                            RX_POWER_STATUS_TWO,
	output logic                            RX_TERMINATION_TEST_MODE,
	output logic                            RX_COLD_START_ONLY,
	output logic                            RX_CUSTOMER_INTERFACE_ACTIVITY,
	output logic                            RX_FAR_END_BLOCK_ERROR,
	// Block error reporting
	output logic                            RX_CRC_CHECKED,
	output logic                            RX_BLOCK_ERROR
);
	typedef enum logic [1:0] {
		st_hunt = 2'b01,
		st_lock = 2'b10
	} lomc_rx_state_t;
	// Transmit state
	logic                             bit_tick;
	logic [lomc_pkg::POS_W-1:0]       tx_pos;
	logic [lomc_pkg::FRM_W-1:0]       tx_frm;
	logic [lomc_pkg::EOC_W-1:0]       tx_eoc;
	logic [lomc_pkg::CRC_W-1:0]       tx_crc_state;
	logic [lomc_pkg::CRC_W-1:0]       tx_crc_send;
	logic                             tx_far_end_block_error;
	// Receive state
	lomc_rx_state_t                   rx_state;
	lomc_rx_state_t                   next_rx_state;
	logic [lomc_pkg::POS_W-1:0]       rx_pos;
	logic [lomc_pkg::FRM_W-1:0]       rx_frm;
	logic [lomc_pkg::CRC_W-1:0]       rx_crc_state;
	logic [lomc_pkg::CRC_W-1:0]       rx_crc_expect;
	logic [lomc_pkg::CRC_W-1:0]       rx_crc_sh;
	logic [lomc_pkg::EOC_W-1:0]       rx_eoc_sh;
	logic                             rx_expect_valid;
	logic                             rx_mf_seen;
	lomc_bit_tick u_tick (
		.clk    (CLK),
		.rst    (SYS_RST),
		.enable (TX_ENABLE),
		.tick   (bit_tick)
	);
	// Transmit position decode
	wire logic tx_pos_end = tx_pos == lomc_pkg::POS_LAST;
	wire logic [lomc_pkg::POS_W-1:0] next_tx_pos = tx_pos_end ?
		lomc_pkg::POS_FIRST : lomc_pkg::POS_W'(tx_pos + 1'b1);
	// Frame count wraps after the eighth frame
	wire logic [lomc_pkg::FRM_W-1:0] next_tx_frm = tx_pos_end ?
		lomc_pkg::FRM_W'(tx_frm + 1'b1) : tx_frm;
	wire logic tx_mf_first = tx_pos == lomc_pkg::POS_FIRST
		&& tx_frm == lomc_pkg::FRM_1;
	wire logic tx_in_fw = tx_pos <= lomc_pkg::FW_LAST;
	wire logic tx_in_data = !tx_in_fw && tx_pos <= lomc_pkg::DATA_LAST;
	// Six overhead bits close the frame at 235..240
	wire logic [2:0] tx_m = lomc_pkg::mbit_sel(tx_pos);
	// Frame one negates each quat, so only sign (odd) bits flip
	wire logic [4:0] tx_fw_idx = 5'(lomc_pkg::FW_LAST - tx_pos);
	wire logic tx_fw_plain = lomc_pkg::FW_PATTERN[tx_fw_idx];
	wire logic tx_fw_bit = (tx_frm == lomc_pkg::FRM_1 && tx_pos[0]) ?
		~tx_fw_plain : tx_fw_plain;
	// M4 indicators toward the far end, reserved ones elsewhere
	wire logic tx_m4_bit =
		(tx_frm == lomc_pkg::FRM_1) ? TX_ACTIVATION_INDICATOR :
		(tx_frm == lomc_pkg::FRM_2) ? TX_DEACTIVATION_INDICATOR :
		(tx_frm == lomc_pkg::FRM_7) ? TX_LINK_LAYER_ONLY_ACTIVATION :
		(tx_frm == lomc_pkg::FRM_8) ? TX_ALARM_INDICATION :
		lomc_pkg::RESERVED_BIT;
	// Operations word bits in M1..M3, two words a multiframe
	wire logic tx_eoc_bit = tx_eoc[lomc_pkg::eoc_index(tx_frm, tx_m)];
	// Check bits in M5/M6 of frames 3..8, bit one from stage 12
	wire logic tx_crc_field = tx_frm >= lomc_pkg::FRM_3;
	wire logic tx_crc_bit =
		tx_crc_send[lomc_pkg::crc_index(tx_frm, tx_m)];
	wire logic tx_far_end_block_error_slot = tx_m == lomc_pkg::M_IDX_6
		&& tx_frm == lomc_pkg::FRM_2;
	wire logic tx_m56_bit = tx_crc_field ? tx_crc_bit :
		tx_far_end_block_error_slot ? tx_far_end_block_error : lomc_pkg::RESERVED_BIT;
	// 24 operations, 12 check and 12 indicator bits per multiframe
	wire logic tx_m_bit = (tx_m <= lomc_pkg::M_IDX_3) ? tx_eoc_bit :
		(tx_m == lomc_pkg::M_IDX_4) ? tx_m4_bit : tx_m56_bit;
	wire logic next_tx_bit = tx_in_fw ? tx_fw_bit :
		tx_in_data ? TX_DATA : tx_m_bit;
	// User handshakes
	assign TX_DATA_TAKE = bit_tick && tx_in_data;
	assign TX_EOC_TAKE = bit_tick && tx_pos == lomc_pkg::POS_FIRST
		&& tx_frm[1:0] == lomc_pkg::FRM_1[1:0];
	// Transmit check generator, cleared as each multiframe starts
	lomc_crc12 u_tx_crc (
		.clk   (CLK),
		.rst   (SYS_RST),
		.clear (bit_tick && tx_mf_first),
		.shift (bit_tick && lomc_pkg::crc_covered(tx_pos)),
		.din   (next_tx_bit),
		.crc   (tx_crc_state)
	);
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tx_pos <= lomc_pkg::POS_FIRST;
			tx_frm <= lomc_pkg::FRM_1;
		end else if (!TX_ENABLE) begin
			tx_pos <= lomc_pkg::POS_FIRST;
			tx_frm <= lomc_pkg::FRM_1;
		end else if (bit_tick) begin
			tx_pos <= next_tx_pos;
			tx_frm <= next_tx_frm;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			tx_eoc      <= lomc_pkg::EOC_IDLE;
			tx_crc_send <= lomc_pkg::CRC_CLEAR;
		end else begin
			if (TX_EOC_TAKE) begin
				tx_eoc <= TX_EOC_WORD;
			end
			if (bit_tick && tx_mf_first) begin
				tx_crc_send <= tx_crc_state;
			end
		end
	end

	// Line outputs; framing flag lets the scrambler skip those bits
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			TX_BIT          <= 1'b0;
			TX_BIT_VALID    <= 1'b0;
			TX_FRAMING_WORD <= 1'b0;
			TX_MF_START     <= 1'b0;
		end else begin
			TX_BIT_VALID <= bit_tick;
			if (bit_tick) begin
				TX_BIT          <= next_tx_bit;
				TX_FRAMING_WORD <= tx_in_fw;
				TX_MF_START     <= tx_mf_first;
			end
		end
	end

	// Receive alignment; frame one is found by the external detector
	always_comb begin
		next_rx_state = rx_state;
		case (rx_state)
			st_hunt: begin
				if (RX_BIT_VALID && RX_MF_START && !RX_SYNC_LOST) begin
					next_rx_state = st_lock;
				end
			end
			st_lock: begin
				if (RX_SYNC_LOST) begin
					next_rx_state = st_hunt;
				end
			end
			default: begin
				next_rx_state = st_hunt;
			end
		endcase
	end
	assign RX_LOCKED = rx_state == st_lock;
	// Receive position decode
	wire logic rx_take = RX_BIT_VALID && !RX_SYNC_LOST
		&& (RX_MF_START || rx_state == st_lock);
	wire logic [lomc_pkg::POS_W-1:0] cur_pos =
		RX_MF_START ? lomc_pkg::POS_FIRST : rx_pos;
	wire logic [lomc_pkg::FRM_W-1:0] cur_frm =
		RX_MF_START ? lomc_pkg::FRM_1 : rx_frm;
	wire logic cur_pos_end = cur_pos == lomc_pkg::POS_LAST;
	wire logic rx_mf_first = cur_pos == lomc_pkg::POS_FIRST
		&& cur_frm == lomc_pkg::FRM_1;
	wire logic rx_in_m = cur_pos >= lomc_pkg::M1_POS;
	wire logic rx_in_data = cur_pos > lomc_pkg::FW_LAST
		&& cur_pos <= lomc_pkg::DATA_LAST;
	wire logic [2:0] rx_m = lomc_pkg::mbit_sel(cur_pos);
	wire logic rx_eoc_take = rx_take && rx_in_m
		&& rx_m <= lomc_pkg::M_IDX_3;
	wire logic rx_eoc_done = rx_eoc_take && rx_m == lomc_pkg::M_IDX_3
		&& cur_frm[1:0] == lomc_pkg::QTR_LAST;
	wire logic rx_m4_take = rx_take && cur_pos == lomc_pkg::M4_POS;
	wire logic rx_crc_take = rx_take && rx_in_m
		&& rx_m >= lomc_pkg::M_IDX_5 && cur_frm >= lomc_pkg::FRM_3;
	wire logic rx_far_end_block_error_take = rx_take && rx_in_m
		&& rx_m == lomc_pkg::M_IDX_6 && cur_frm == lomc_pkg::FRM_2;
	wire logic rx_crc_last = rx_take && cur_pos_end
		&& cur_frm == lomc_pkg::FRM_8;
	// Received check bit one shifted in first lands at the top
	wire logic [lomc_pkg::CRC_W-1:0] rx_crc_got =
		{rx_crc_sh[lomc_pkg::CRC_W-2:0], RX_BIT};
	wire logic rx_mismatch = rx_crc_got != rx_crc_expect;
	wire logic rx_check = rx_crc_last && rx_expect_valid;
	// Receive check generator over the same covered bits
	lomc_crc12 u_rx_crc (
		.clk   (CLK),
		.rst   (SYS_RST),
		.clear (rx_take && rx_mf_first),
		.shift (rx_take && lomc_pkg::crc_covered(cur_pos)),
		.din   (RX_BIT),
		.crc   (rx_crc_state)
	);
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rx_state <= st_hunt;
			rx_pos   <= lomc_pkg::POS_FIRST;
			rx_frm   <= lomc_pkg::FRM_1;
		end else begin
			rx_state <= next_rx_state;
			if (rx_take) begin
				rx_pos <= cur_pos_end ? lomc_pkg::POS_FIRST :
					lomc_pkg::POS_W'(cur_pos + 1'b1);
				rx_frm <= cur_pos_end ?
					lomc_pkg::FRM_W'(cur_frm + 1'b1) : cur_frm;
			end
		end
	end

	// Expected value is the previous multiframe's result
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rx_crc_expect   <= lomc_pkg::CRC_CLEAR;
			rx_expect_valid <= 1'b0;
			rx_mf_seen      <= 1'b0;
		end else if (RX_SYNC_LOST) begin
			rx_expect_valid <= 1'b0;
			rx_mf_seen      <= 1'b0;
		end else if (rx_take && rx_mf_first) begin
			rx_crc_expect   <= rx_crc_state;
			rx_expect_valid <= rx_mf_seen;
			rx_mf_seen      <= 1'b1;
		end
	end

	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			rx_crc_sh <= lomc_pkg::CRC_CLEAR;
			rx_eoc_sh <= lomc_pkg::EOC_IDLE;
		end else begin
			if (rx_crc_take) begin
				rx_crc_sh <= rx_crc_got;
			end
			if (rx_eoc_take) begin
				rx_eoc_sh <= {rx_eoc_sh[lomc_pkg::EOC_W-2:0], RX_BIT};
			end
		end
	end

	// Check result pulses and far-end error bit for the next send
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RX_CRC_CHECKED <= 1'b0;
			RX_BLOCK_ERROR <= 1'b0;
			tx_far_end_block_error        <= lomc_pkg::RESERVED_BIT;
		end else begin
			RX_CRC_CHECKED <= rx_check;
			RX_BLOCK_ERROR <= rx_check && rx_mismatch;
			if (rx_check) begin
				tx_far_end_block_error <= ~rx_mismatch;
			end
		end
	end

	// User data and operations words
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RX_USER_BIT   <= 1'b0;
			RX_USER_VALID <= 1'b0;
			RX_EOC_WORD   <= lomc_pkg::EOC_IDLE;
			RX_EOC_VALID  <= 1'b0;
		end else begin
			RX_USER_VALID <= rx_take && rx_in_data;
			RX_EOC_VALID  <= rx_eoc_done;
			if (rx_take) begin
				RX_USER_BIT <= RX_BIT;
			end
			if (rx_eoc_done) begin
				RX_EOC_WORD <= {rx_eoc_sh[lomc_pkg::EOC_W-2:0], RX_BIT};
			end
		end
	end
	// Indicators from the far end, raw bit values
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			RX_ACTIVATION_INDICATOR        <= lomc_pkg::RESERVED_BIT;
			RX_POWER_STATUS_ONE            <= lomc_pkg::RESERVED_BIT;
			RX_POWER_STATUS_TWO            <= lomc_pkg::RESERVED_BIT;
			RX_TERMINATION_TEST_MODE       <= lomc_pkg::RESERVED_BIT;
			RX_COLD_START_ONLY             <= lomc_pkg::COLD_IDLE;
			RX_CUSTOMER_INTERFACE_ACTIVITY <= lomc_pkg::RESERVED_BIT;
			RX_FAR_END_BLOCK_ERROR         <= lomc_pkg::RESERVED_BIT;
		end else begin
			if (rx_far_end_block_error_take) begin
				RX_FAR_END_BLOCK_ERROR <= RX_BIT;
			end
			if (rx_m4_take) begin
				case (cur_frm)
					lomc_pkg::FRM_1: RX_ACTIVATION_INDICATOR <= RX_BIT;
					lomc_pkg::FRM_2: RX_POWER_STATUS_ONE <= RX_BIT;
					lomc_pkg::FRM_3: RX_POWER_STATUS_TWO <= RX_BIT;
					lomc_pkg::FRM_4: RX_TERMINATION_TEST_MODE <= RX_BIT;
					lomc_pkg::FRM_5: RX_COLD_START_ONLY <= RX_BIT;
					lomc_pkg::FRM_7: begin
						RX_CUSTOMER_INTERFACE_ACTIVITY <= RX_BIT;
					end
					default: begin
					end
				endcase
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/lomc_framer_monitor.sv */
// Port-level assertions for the overhead framer
`timescale 1ns/1ps
`default_nettype none
module lomc_framer_monitor (
	// Clock and reset
	input  wire logic CLK,
	input  wire logic SYS_RST,
	// Transmit side
	input  wire logic TX_DATA,
	input  wire logic TX_DATA_TAKE,
	input  wire logic TX_EOC_TAKE,
	input  wire logic TX_BIT,
	input  wire logic TX_BIT_VALID,
	input  wire logic TX_FRAMING_WORD,
	input  wire logic TX_MF_START,
	// Receive side
	input  wire logic RX_BIT_VALID,
	input  wire logic RX_SYNC_LOST,
	input  wire logic RX_LOCKED,
	input  wire logic RX_USER_VALID,
	input  wire logic RX_EOC_VALID,
	input  wire logic RX_CRC_CHECKED,
	input  wire logic RX_BLOCK_ERROR
);
	default clocking @(posedge CLK); endclocking
	default disable iff (SYS_RST);
	logic [10:0] gap;
	logic        seen;
	always_ff @(posedge CLK or posedge SYS_RST) begin
		if (SYS_RST) begin
			gap  <= 11'h000;
			seen <= 1'b0;
		end else if (TX_BIT_VALID) begin
			gap  <= 11'h000;
			seen <= 1'b1;
		end else begin
			gap <= gap + 11'h001;
		end
	end
	bit_spacing_a: assert property (TX_BIT_VALID && seen |-> gap == 11'h4E1)
		else $error("line bit spacing wrong");
	data_into_bit_a: assert property (TX_DATA_TAKE |=> TX_BIT_VALID
		&& !TX_FRAMING_WORD && TX_BIT == $past(TX_DATA))
		else $error("user bit not sent next");
	mf_word_start_a: assert property (TX_BIT_VALID && TX_MF_START
		|-> TX_FRAMING_WORD && !TX_BIT)
		else $error("frame one does not open inverted");
	eoc_take_a: assert property (TX_EOC_TAKE |=> TX_BIT_VALID && TX_FRAMING_WORD)
		else $error("ops word taken off frame start");
	error_needs_check_a: assert property (RX_BLOCK_ERROR |-> RX_CRC_CHECKED)
		else $error("block error without check");
	check_on_last_a: assert property (RX_CRC_CHECKED |-> $past(RX_BIT_VALID)
		&& $past(RX_LOCKED) && !RX_USER_VALID)
		else $error("check not after last bit");
	user_follows_a: assert property (RX_USER_VALID |-> $past(RX_BIT_VALID))
		else $error("user bit without line bit");
	eoc_follows_a: assert property (RX_EOC_VALID |-> $past(RX_BIT_VALID))
		else $error("ops word without line bit");
	lock_drop_a: assert property (RX_SYNC_LOST |=> !RX_LOCKED)
		else $error("lock kept after sync loss");
endmodule
bind lomc_framer lomc_framer_monitor i_lomc_framer_monitor (
	.CLK(CLK), .SYS_RST(SYS_RST), .TX_DATA(TX_DATA),
	.TX_DATA_TAKE(TX_DATA_TAKE), .TX_EOC_TAKE(TX_EOC_TAKE),
	.TX_BIT(TX_BIT), .TX_BIT_VALID(TX_BIT_VALID),
	.TX_FRAMING_WORD(TX_FRAMING_WORD), .TX_MF_START(TX_MF_START),
	.RX_BIT_VALID(RX_BIT_VALID), .RX_SYNC_LOST(RX_SYNC_LOST),
	.RX_LOCKED(RX_LOCKED), .RX_USER_VALID(RX_USER_VALID),
	.RX_EOC_VALID(RX_EOC_VALID), .RX_CRC_CHECKED(RX_CRC_CHECKED),
	.RX_BLOCK_ERROR(RX_BLOCK_ERROR)
);
`default_nettype wire

/* File: tb/lomc_far_end.sv */
// Far-end line transceiver model feeding the receive side
`timescale 1ns/1ps
`default_nettype none
module lomc_far_end (
	// Clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// Control from the bench
	input  wire logic        run,
	input  wire logic        corrupt,
	input  wire logic [11:0] eoc_word,
	input  wire logic [7:0]  m4_bits,
	input  wire logic        far_end_block_error,
	// Line toward the framer
	output logic             bit_out,
	output logic             bit_valid,
	output logic             mf_start
);
	logic [7:0]  pos;
	logic [2:0]  frm;
	logic [11:0] crc;
	logic [11:0] crc_prev;
	logic        ph;
	logic        ob;
	logic        nb;
	wire  logic [7:0]  mo  = pos - 8'hEB;
	wire  logic        cov = (pos > 8'h12 && pos < 8'hEB) || pos == 8'hEE;
	wire  logic [3:0]  ei  = 4'hB - (4'(frm[1:0]) * 4'h3 + 4'(mo[1:0]));
	wire  logic [3:0]  ci  = 4'hB - {frm - 3'h2, mo[0]};
	wire  logic [17:0] fw  = (frm == 3'h0) ? 18'h0_2A20 : 18'h2_808A;
	always_comb begin
		case (mo[2:0])
			3'h3: ob = m4_bits[frm];
			3'h4: ob = (frm < 3'h2) ? 1'b1 : crc_prev[ci] ^ corrupt;
			3'h5: ob = (frm == 3'h0) ? 1'b1 : (frm == 3'h1) ? far_end_block_error : crc_prev[ci];
			default: ob = eoc_word[ei];
		endcase
		if (pos <= 8'h12) begin
			nb = fw[8'h12 - pos];
		end else if (pos <= 8'hEA) begin
			nb = pos[0] ^ pos[3] ^ frm[1];
		end else begin
			nb = ob;
		end
	end
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			pos       <= 8'h01;
			frm       <= 3'h0;
			ph        <= 1'b0;
			crc       <= 12'h000;
			crc_prev  <= 12'h000;
			bit_out   <= 1'b0;
			bit_valid <= 1'b0;
			mf_start  <= 1'b0;
		end else begin
			bit_valid <= run && ph;
			ph        <= run && !ph;
			if (run && ph) begin
				bit_out  <= nb;
				mf_start <= pos == 8'h01 && frm == 3'h0;
				pos      <= (pos == 8'hF0) ? 8'h01 : pos + 8'h01;
				if (pos == 8'hF0) frm <= frm + 3'h1;
				if (pos == 8'h01 && frm == 3'h0) begin
					crc_prev <= crc;
					crc      <= 12'h000;
				end else if (cov) begin
					crc <= {crc[10:0], 1'b0} ^ ({12{nb ^ crc[11]}} & 12'h80F);
				end
			end else begin
				bit_out  <= ~bit_out;
				mf_start <= 1'b0;
			end
		end
	end
endmodule
`default_nettype wire

/* File: tb/testbench.sv */
// Self-checking bench for the overhead framer
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic        CLK = 1'b0;
	logic        SYS_RST = 1'b1;
	logic        RX_SYNC_LOST = 1'b0;
	logic        run = 1'b0;
	logic        corrupt = 1'b0;
	logic        tx_en = 1'b0, tx_data = 1'b1, far_far_end_block_error = 1'b0, user_bit;
	logic [7:0]  far_m4 = 8'hB0;
	logic [11:0] far_eoc = 12'hA5C;
	logic        rx_bit, rx_valid, rx_mf, take, eoc_take, tx_bit, tx_valid;
	logic        tx_fw, tx_mf, locked, eoc_valid, user_valid, checked, blk_err;
	logic [11:0] eoc_word;
	logic [6:0]  ind;
	logic [17:0] fw = 18'h0_0000;
	int          failures = 0, total_checks = 0, cycles = 0;
	int          n_take = 0, n_eoc = 0, n_user = 0, n_rxeoc = 0;
	int          user_mf = 0, rxeoc_mf = 0, n_one = 0, one_mf = 0;
	always #2.5 CLK = ~CLK;
	lomc_framer i_lomc_framer (
		.CLK(CLK), .SYS_RST(SYS_RST), .TX_ENABLE(tx_en), .TX_DATA(tx_data),
		.TX_DATA_TAKE(take), .TX_EOC_WORD(12'h5A3), .TX_EOC_TAKE(eoc_take),
		.TX_ACTIVATION_INDICATOR(1'b1), .TX_DEACTIVATION_INDICATOR(1'b1),
		.TX_LINK_LAYER_ONLY_ACTIVATION(1'b1), .TX_ALARM_INDICATION(1'b1),
		.TX_BIT(tx_bit), .TX_BIT_VALID(tx_valid), .TX_FRAMING_WORD(tx_fw),
		.TX_MF_START(tx_mf), .RX_BIT(rx_bit), .RX_BIT_VALID(rx_valid),
		.RX_MF_START(rx_mf), .RX_SYNC_LOST(RX_SYNC_LOST), .RX_LOCKED(locked),
		.RX_USER_BIT(user_bit), .RX_USER_VALID(user_valid),
		.RX_EOC_WORD(eoc_word),
		.RX_EOC_VALID(eoc_valid), .RX_ACTIVATION_INDICATOR(ind[6]),
		.RX_POWER_STATUS_ONE(ind[5]), .RX_POWER_STATUS_TWO(ind[4]),
		.RX_TERMINATION_TEST_MODE(ind[3]), .RX_COLD_START_ONLY(ind[2]),
		.RX_CUSTOMER_INTERFACE_ACTIVITY(ind[1]),
		.RX_FAR_END_BLOCK_ERROR(ind[0]), .RX_CRC_CHECKED(checked),
		.RX_BLOCK_ERROR(blk_err)
	);
	lomc_far_end i_lomc_far_end (
		.clk(CLK), .rst(SYS_RST), .run(run), .corrupt(corrupt),
		.eoc_word(far_eoc), .m4_bits(far_m4), .far_end_block_error(far_far_end_block_error),
		.bit_out(rx_bit), .bit_valid(rx_valid), .mf_start(rx_mf)
	);
	task automatic end_of_test();
		if (failures == 0 && total_checks > 0) begin
			$display("All tests passed");
		end else begin
			$display("Some tests failed");
		end
		$finish;
	endtask
	task automatic check_bit(input string name, input logic got, input logic exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %b seen %b", name, exp, got);
		end
	endtask
	task automatic check_num(input string name, input logic [17:0] got,
			input logic [17:0] exp);
		total_checks++;
		if (got !== exp) begin
			failures++;
			$display("mismatch %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic wait_pulse(input logic rx_side, input int limit);
		int n;
		n = 0;
		do begin
			@(posedge CLK);
			#1;
			n++;
		end while ((rx_side ? checked : tx_valid) !== 1'b1 && n < limit);
		check_bit("pulse_wait", 1'(n < limit), 1'b1);
	endtask
	always @(posedge CLK) begin
		cycles++;
		n_take += int'(take);
		n_eoc += int'(eoc_take);
		if (checked === 1'b1) begin
			user_mf = n_user;
			rxeoc_mf = n_rxeoc;
			one_mf = n_one;
			n_user = 0;
			n_rxeoc = 0;
			n_one = 0;
		end
		n_user += int'(user_valid);
		n_one += int'(user_valid && user_bit);
		n_rxeoc += int'(eoc_valid);
		if (cycles == 60000) begin
			failures++;
			end_of_test();
		end
	end
	initial begin
		repeat (20) @(posedge CLK);
		#1 SYS_RST = 1'b0;
		tx_en = 1'b1;
		check_bit("rx_locked", locked, 1'b0);
		check_num("rx_eoc_word", 18'(eoc_word), 18'h0_0FFF);
		check_num("rx_indicators", 18'(ind), 18'h0_007B);
		for (int i = 1; i <= 19; i++) begin
			wait_pulse(1'b0, 1300);
			if (i == 1) check_bit("tx_mf_start", tx_mf, 1'b1);
			if (i <= 18) fw = {fw[16:0], tx_bit};
		end
		check_num("tx_framing_word", fw, 18'h0_2A20);
		check_bit("tx_word_flag", tx_fw, 1'b0);
		check_bit("tx_first_data", tx_bit, 1'b1);
		check_num("tx_data_takes", 18'(n_take), 18'h0_0001);
		check_num("tx_eoc_takes", 18'(n_eoc), 18'h0_0001);
		tx_data = 1'b0;
		wait_pulse(1'b0, 1300);
		check_bit("tx_second_data", tx_bit, 1'b0);
		run = 1'b1;
		wait_pulse(1'b1, 9000);
		check_bit("rx_block_error", blk_err, 1'b0);
		check_bit("rx_locked", locked, 1'b1);
		check_num("rx_eoc_word", 18'(eoc_word), 18'h0_0A5C);
		check_num("rx_indicators", 18'(ind), 18'h0_0004);
		corrupt = 1'b1;
		wait_pulse(1'b1, 4000);
		check_bit("rx_block_error", blk_err, 1'b1);
		@(posedge CLK);
		#1 corrupt = 1'b0;
		far_far_end_block_error = 1'b1;
		far_m4 = 8'h35;
		far_eoc = 12'h3C6;
		check_num("rx_user_bits", 18'(user_mf), 18'h0_06C0);
		check_num("rx_user_ones", 18'(one_mf), 18'h0_0360);
		check_num("rx_eoc_words", 18'(rxeoc_mf), 18'h0_0002);
		wait_pulse(1'b1, 4000);
		check_bit("rx_block_error", blk_err, 1'b0);
		check_num("rx_eoc_word", 18'(eoc_word), 18'h0_03C6);
		check_num("rx_indicators", 18'(ind), 18'h0_0055);
		@(posedge CLK);
		#1 RX_SYNC_LOST = 1'b1;
		@(posedge CLK);
		#1 RX_SYNC_LOST = 1'b0;
		check_bit("rx_locked", locked, 1'b0);
		end_of_test();
	end
endmodule
`default_nettype wire
